/* src/bfpc_top.sv */
// Bus-failure pulse cancel delay: holds safety outputs, freezes bus inputs, delays pulse enable withdrawal.
//
// Function
// R1 - Delay pulse-enable withdrawal after bus failure.
// R2 - Zero delay means immediate withdrawal.
// R3 - Hold safety outputs during the delay.
// R4 - Clear safety outputs when delay expires.
// R5 - Stop axial monitoring on bus failure.
// R6 - External immediate stop cuts pulses at once.
// R7 - Test stop or pulse test cuts immediately.
// R8 - Safe standstill selection cuts pulses immediately.
// R9 - Excluded velocity stage cuts pulses immediately.
// R10 - Bus I/O modules zero outputs themselves.
// R11 - Keep local inputs live, freeze bus inputs.
// R12 - Ignore new axial selections during failure.
// R13 - Logic program emergency-off cuts pulses early.
// R14 - Logic uses last valid bus input image.
// R15 - Secondary logic channel loses selection power.
// R16 - Drive channel keeps its active function.
// R17 - Delay counter starts at failure detection.
`timescale 1ns/10ps
`default_nettype none
module bfpc_top #(
  parameter int unsigned OUT_W   = 8,                   // Number of axial safety outputs.
  parameter int unsigned IN_W    = 8,                   // Width of each input image.
  parameter int unsigned STAGE_N = 4,                   // Number of safe velocity stages.
  parameter int unsigned UNIT    = bfpc_pkg::UNIT_CYCLES // Cycles per ms, shorten in simulation.
) (
  input  wire logic               REF_CLK,
  input  wire logic               RST_N,
  // Register port.
  input  wire logic [3:0]         REG_ADDR,
  input  wire logic [31:0]        REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic [31:0]             REG_RDATA,
  output logic                    IRQ,
  // Bus state and selections.
  input  wire logic               BUS_FAIL,
  input  wire logic               EXT_STOP_SEL,
  input  wire logic               TEST_STOP_SEL,
  input  wire logic               SAFE_STANDSTILL_SELECT,
  input  wire logic [STAGE_N-1:0] SAFE_VELOCITY_STAGE,
  input  wire logic [1:0]         SAFE_END_POSITION_STAGE,
  input  wire logic               LOGIC_EMERG_OFF,
  input  wire logic               SEC_STOP_REQ,
  input  wire logic               SEC_SEL_REQ,
  // Monitoring and safety signals.
  input  wire logic [OUT_W-1:0]   SAFETY_OUTPUT_SIGNALS_IN,
  input  wire logic [IN_W-1:0]    LOCAL_INPUTS,
  input  wire logic [IN_W-1:0]    BUS_IO_MODULE_INPUTS,
  input  wire logic               PULSE_ENABLE_REQ,
  output logic [OUT_W-1:0]        SAFETY_OUTPUT_SIGNALS,
  output logic [IN_W-1:0]         LOCAL_INPUT_IMAGE,
  output logic [IN_W-1:0]         LOGIC_EXTERNAL_INPUTS,
  output logic [1:0]              END_POS_STAGE_ACTIVE,
  output logic                    MONITOR_ENABLE,
  output logic                    SEC_CHANNEL_ENABLE,
  output logic                    PULSE_ENABLE
);
  import bfpc_pkg::*;

  // ---------------------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------------------
  typedef struct packed {
    bfpc_state_t              st;                       // Bus-failure state.
    logic [DELAY_W-1:0]       delay;                    // Delay setting in ms.
    logic [STAGE_N-1:0]       stage_mask;               // Stages that exclude the stop.
    logic                     global_excl;              // All stages exclude the stop.
    logic [ST_W-1:0]          status;                   // Sticky event flags.
    logic [ST_W-1:0]          mask;                     // Interrupt mask.
    logic [OUT_W-1:0]         out_img;                  // Safety outputs as driven.
    logic [IN_W-1:0]          loc_img;                  // Local input image.
    logic [IN_W-1:0]          bus_img;                  // Bus module input image.
    logic [1:0]               end_pos;                  // Active end-position stage.
    logic                     pulse;                    // Pulse enable to the terminal.
    logic [31:0]              rdata;                    // Read data for the next cycle.
  } bfpc_top_t;

  bfpc_top_t s_q, s_d;                                  // Registered and next state.
  logic      fail_edge;                                 // First cycle of a bus failure.
  logic      imm_cut;                                   // Any immediate cancellation cause.
  logic      tmr_done;                                  // Delay expired.
  logic      excl_stage;                                // Excluded velocity stage selected.
  logic [ST_W-1:0] ev;                                  // Events raised in this cycle.

  // Is any selected velocity stage excluded from the autonomous stop.
  function automatic logic stage_excluded(input logic [STAGE_N-1:0] sel,
                                          input logic [STAGE_N-1:0] msk,
                                          input logic               glob);
    stage_excluded = |sel && (glob || |(sel & msk));
  endfunction : stage_excluded

  // ---------------------------------------------------------------------------
  // Delay timer
  // ---------------------------------------------------------------------------
  bfpc_timer #(.UNIT(UNIT)) u_timer (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .START   (fail_edge),
    .RUN     (s_q.st == BF_DELAY),
    .LIMIT   (s_q.delay),
    .DONE    (tmr_done)
  );

  // Immediate causes; the secondary channel has no say here, so its stop request
  // is only honoured while the bus is healthy.
  always_comb begin
    fail_edge  = BUS_FAIL && (s_q.st == BF_RUN);
    excl_stage = stage_excluded(SAFE_VELOCITY_STAGE, s_q.stage_mask, s_q.global_excl); // R9
    imm_cut    = EXT_STOP_SEL                           // R6
               || TEST_STOP_SEL                         // R7
               || SAFE_STANDSTILL_SELECT                // R8
               || excl_stage                            // R9
               || LOGIC_EMERG_OFF;                      // R13
  end

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.loc_img = LOCAL_INPUTS;                         // R11
    s_d.rdata   = '0;
    ev          = '0;
    case (s_q.st)
      // Normal running: track everything live.
      BF_RUN: begin
        s_d.out_img = SAFETY_OUTPUT_SIGNALS_IN;
        s_d.end_pos = SAFE_END_POSITION_STAGE;
        // The image that arrives with the failure is already invalid, so keep the one before it.
        if (!BUS_FAIL) begin                            // R14
          s_d.bus_img = BUS_IO_MODULE_INPUTS;
        end
        // A secondary stop counts only while the bus is healthy.
        s_d.pulse   = PULSE_ENABLE_REQ && !(SEC_STOP_REQ && !BUS_FAIL); // R15
        if (BUS_FAIL) begin
          ev[ST_FAIL] = 1'b1;
          if (s_q.delay == '0 || imm_cut) begin         // R2
            s_d.st    = BF_CUT;
            s_d.pulse = 1'b0;
            s_d.out_img = '0;
            if (imm_cut) begin
              ev[ST_IMM] = 1'b1;
            end
          end else begin
            s_d.st = BF_DELAY;                          // R1
          end
        end
      end
      // Delay running: outputs, bus images and end stage stay frozen.
      BF_DELAY: begin                                   // R3 R12 R14
        if (imm_cut) begin                              // R6 R7 R8 R9 R13
          s_d.st      = BF_CUT;
          s_d.pulse   = 1'b0;
          s_d.out_img = '0;
          ev[ST_IMM]  = 1'b1;
        end else if (tmr_done) begin
          s_d.st      = BF_CUT;
          s_d.pulse   = 1'b0;                           // R1
          s_d.out_img = '0;                             // R4
          ev[ST_EXPIR] = 1'b1;
        end
      end
      // Pulses cut; wait for the bus to recover.
      BF_CUT: begin
        s_d.pulse   = 1'b0;
        s_d.out_img = '0;                               // R4
        if (!BUS_FAIL) begin
          s_d.st = BF_RUN;
        end
      end
      default: begin
        s_d.st = BF_CUT;
      end
    endcase

    // Sticky flags collect this cycle's events.
    s_d.status = s_q.status | ev;

    // Register writes.
    if (REG_WR) begin
      case (REG_ADDR)
        REG_DELAY:   s_d.delay = REG_WDATA[DELAY_W-1:0];
        REG_STOPCFG: begin
          s_d.stage_mask  = REG_WDATA[STAGE_N-1:0];
          s_d.global_excl = REG_WDATA[CFG_GLOBAL_BIT];
        end
        REG_MASK:    s_d.mask = REG_WDATA[ST_W-1:0];
        default:     ;
      endcase
    end

    // Register reads; status clears on read but a new event wins.
    if (REG_RD) begin
      case (REG_ADDR)
        REG_DELAY:   s_d.rdata = 32'(s_q.delay);
        REG_STOPCFG: s_d.rdata = 32'(s_q.stage_mask) | (32'(s_q.global_excl) << CFG_GLOBAL_BIT);
        REG_STATUS: begin
          s_d.rdata  = 32'(s_q.status);
          s_d.status = ev;                              // An event in the read cycle survives the clear.
        end
        REG_MASK:    s_d.rdata = 32'(s_q.mask);
        REG_STATE:   s_d.rdata = {29'h0000000, s_q.pulse, 2'(s_q.st)};
        default:     s_d.rdata = '0;
      endcase
    end
  end

  // Register all state.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q       <= '0;
      s_q.st    <= BF_RUN;
      s_q.delay <= DELAY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign REG_RDATA             = s_q.rdata;
  assign IRQ                   = |(s_q.status & s_q.mask);
  assign SAFETY_OUTPUT_SIGNALS = s_q.out_img;           // R3
  assign LOCAL_INPUT_IMAGE     = s_q.loc_img;           // R11
  assign LOGIC_EXTERNAL_INPUTS = s_q.bus_img;           // R14
  assign END_POS_STAGE_ACTIVE  = s_q.end_pos;           // R12
  assign MONITOR_ENABLE        = (s_q.st == BF_RUN);    // R5
  assign SEC_CHANNEL_ENABLE    = (s_q.st == BF_RUN) && SEC_SEL_REQ; // R15
  assign PULSE_ENABLE          = s_q.pulse;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  zero_delay_cut_a: assert property (BUS_FAIL && s_q.st == BF_RUN && s_q.delay == '0 |=> !PULSE_ENABLE) // R2
    else $error("Zero delay did not cut pulses at once.");
  immediate_cut_a: assert property (s_q.st == BF_DELAY && EXT_STOP_SEL |=> !PULSE_ENABLE) // R6
    else $error("External stop did not cut pulses.");
  test_cut_a: assert property (s_q.st == BF_DELAY && TEST_STOP_SEL |=> s_q.st == BF_CUT) // R7
    else $error("Test stop did not cut pulses.");
  standstill_cut_a: assert property (s_q.st == BF_DELAY && SAFE_STANDSTILL_SELECT |=> !PULSE_ENABLE) // R8
    else $error("Standstill did not cut pulses.");
  outputs_held_a: assert property (s_q.st == BF_DELAY && !imm_cut && !tmr_done |=> // R3
    $stable(SAFETY_OUTPUT_SIGNALS))
    else $error("Safety outputs changed during the delay.");
  outputs_cleared_a: assert property (s_q.st == BF_CUT |-> SAFETY_OUTPUT_SIGNALS == '0) // R4
    else $error("Safety outputs not cleared after cut.");
  monitor_off_a: assert property (fail_edge |=> !MONITOR_ENABLE) // R5
    else $error("Monitoring still enabled after bus failure.");
  bus_image_frozen_a: assert property (s_q.st == BF_DELAY |=> $stable(LOGIC_EXTERNAL_INPUTS)) // R14
    else $error("Bus input image changed during failure.");
  sec_channel_off_a: assert property (s_q.st != BF_RUN |-> !SEC_CHANNEL_ENABLE) // R15
    else $error("Secondary channel active during failure.");
  delay_start_a: assert property (fail_edge && s_q.delay != '0 && !imm_cut |=> // R1
    s_q.st == BF_DELAY && PULSE_ENABLE == $past(PULSE_ENABLE_REQ))
    else $error("Delay did not start on bus failure.");
  fail_image_kept_a: assert property (fail_edge |=> // R14
    LOGIC_EXTERNAL_INPUTS == $past(LOGIC_EXTERNAL_INPUTS))
    else $error("Bus input image taken at the failure instant.");

  delay_cover_c:   cover property (s_q.st == BF_DELAY ##1 tmr_done);
  imm_cover_c:     cover property (s_q.st == BF_DELAY && imm_cut);
  recover_cover_c: cover property (s_q.st == BF_CUT ##1 s_q.st == BF_RUN);

endmodule : bfpc_top
`default_nettype wire

/* src/bfpc_pkg.sv */
// Package of constants, states and register map for the bus-failure pulse cancel delay block.
package bfpc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 20;          // Control clock period in ns.
  localparam int unsigned DELAY_UNIT_US  = 1000;        // One delay unit is one millisecond.
  localparam int unsigned UNIT_CYCLES    =
    (DELAY_UNIT_US * 1000) / CLK_PERIOD_NS;             // Cycles per delay unit.
  localparam int unsigned DELAY_W        = 16;          // Width of the delay setting in ms.
  localparam int unsigned PRESC_W        = 16;          // Width of the millisecond prescaler.

  // ---------------------------------------------------------------------------
  // Register map, word addresses on the plain port
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_DELAY   = 4'h0;            // Bus-failure delay setting in ms.
  localparam logic [3:0] REG_STOPCFG = 4'h1;            // Per-stage no-stop masks and global flag.
  localparam logic [3:0] REG_STATUS  = 4'h2;            // Sticky event flags, cleared on read.
  localparam logic [3:0] REG_MASK    = 4'h3;            // Interrupt mask, same layout as status.
  localparam logic [3:0] REG_STATE   = 4'h4;            // Live state of the block.

  // Configuration register fields.
  localparam int unsigned CFG_GLOBAL_BIT = 8;           // Global exclusion of autonomous stop.
  localparam logic [15:0] DELAY_RST      = 16'h0000;    // Delay off after reset.

  // Status bit positions.
  localparam int unsigned ST_FAIL  = 0;                 // Bus failure detected.
  localparam int unsigned ST_IMM   = 1;                 // Immediate pulse cancellation forced.
  localparam int unsigned ST_EXPIR = 2;                 // Delay expired.
  localparam int unsigned ST_W     = 3;                 // Number of status bits.

  // Block states.
  typedef enum logic [1:0] {
    BF_RUN,
    BF_DELAY,
    BF_CUT
  } bfpc_state_t;

endpackage : bfpc_pkg

/* src/bfpc_timer.sv */
// Delay timer that counts milliseconds from the cycle of bus failure detection.
`timescale 1ns/10ps
`default_nettype none
module bfpc_timer #(
  parameter int unsigned UNIT = bfpc_pkg::UNIT_CYCLES
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RST_N,
  input  wire logic                          START,
  input  wire logic                          RUN,
  input  wire logic [bfpc_pkg::DELAY_W-1:0]  LIMIT,
  output logic                               DONE
);
  import bfpc_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [PRESC_W-1:0] presc;                          // Cycles within the current ms.
    logic [DELAY_W-1:0] ms;                             // Whole ms elapsed.
  } bfpc_tmr_t;

  bfpc_tmr_t s_q, s_d;                                  // Registered and next state.

  localparam logic [PRESC_W-1:0] UNIT_LAST = PRESC_W'(UNIT - 1);

  // Count ms on the control clock; START restarts at zero.
  always_comb begin
    s_d = s_q;
    if (START) begin                                    // R17
      s_d.presc = '0;
      s_d.ms    = '0;
    end else if (RUN && (s_q.ms < LIMIT)) begin
      if (s_q.presc == UNIT_LAST) begin
        s_d.presc = '0;
        s_d.ms    = s_q.ms + 1'b1;
      end else begin
        s_d.presc = s_q.presc + 1'b1;
      end
    end
  end

  // Register the state.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Terminal count is the delay setting in ms.
  assign DONE = RUN && !START && (s_q.ms >= LIMIT);     // R17

endmodule : bfpc_timer
`default_nettype wire

/* test/bfpc_far_model.sv */
// Far-side model: the drive bus, its I/O modules and the drive monitoring channel.
`timescale 1ns/10ps
`default_nettype none
module bfpc_far_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       fail_cmd,   // Bench command to break the bus.
  input  wire logic [7:0] io_val,     // Level at the module input terminals.
  input  wire logic [7:0] out_cmd,    // Outputs the device asks the modules to show.
  input  wire logic [1:0] func_sel,   // Axial function selected in the drive.
  output logic            bus_fail,   // Failure seen by the device.
  output logic [7:0]      io_image,   // Input image delivered over the bus.
  output logic [7:0]      io_out,     // Module output terminals.
  output logic [1:0]      drive_func  // Function the drive keeps running.
);
  logic [7:0] spin_q;  // Moves every cycle, so a stale image never passes for a frozen one.

  // --------------------------------------------------------------------------
  // Bus state and drive channel
  // --------------------------------------------------------------------------
  // The drive keeps the function that was active at the failure instant.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_fail   <= 1'b0;
      spin_q     <= 8'h00;
      drive_func <= 2'h0;
    end else begin
      bus_fail <= fail_cmd;
      spin_q   <= spin_q + 8'h5B;
      if (!fail_cmd) begin
        drive_func <= func_sel;
      end
    end
  end

  // A dead bus carries no valid data; show a changing pattern instead.
  assign io_image = bus_fail ? (io_val ^ spin_q ^ 8'hA5) : io_val;
  // Modules clear their outputs at once when the bus fails.
  assign io_out = bus_fail ? 8'h00 : out_cmd;
endmodule : bfpc_far_model
`default_nettype wire

/* test/tb.sv */
// Self-checking testbench for the bus-failure pulse cancel delay block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bfpc_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} bfpc_note_t;

  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [3:0] reg_addr = 4'h0, cs = 4'h0, stage = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic fail_cmd = 1'b0, sec_stop = 1'b0, sec_sel = 1'b0, pulse_req = 1'b1, irq, bus_fail;
  logic [1:0] end_sel = 2'h0, end_act, drive_func;
  logic [7:0] so_in = 8'h0, li = 8'h0, io_val = 8'h0, io_img, so, li_img, lx, io_out, v, w;
  logic mon_en, sec_en, pulse;
  int fail_count = 0, comparisons = 0, cycles = 0, seed = 32'haaf90055;
  bfpc_note_t notes[$];
  bfpc_note_t n;

  always #10 clk = ~clk;

  bfpc_top #(.OUT_W(8), .IN_W(8), .STAGE_N(4), .UNIT(4)) u_bfpc_top (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq), .BUS_FAIL(bus_fail), .EXT_STOP_SEL(cs[0]),
    .TEST_STOP_SEL(cs[1]), .SAFE_STANDSTILL_SELECT(cs[2]), .SAFE_VELOCITY_STAGE(stage),
    .SAFE_END_POSITION_STAGE(end_sel), .LOGIC_EMERG_OFF(cs[3]), .SEC_STOP_REQ(sec_stop),
    .SEC_SEL_REQ(sec_sel), .SAFETY_OUTPUT_SIGNALS_IN(so_in), .LOCAL_INPUTS(li),
    .BUS_IO_MODULE_INPUTS(io_img), .PULSE_ENABLE_REQ(pulse_req), .SAFETY_OUTPUT_SIGNALS(so),
    .LOCAL_INPUT_IMAGE(li_img), .LOGIC_EXTERNAL_INPUTS(lx), .END_POS_STAGE_ACTIVE(end_act),
    .MONITOR_ENABLE(mon_en), .SEC_CHANNEL_ENABLE(sec_en), .PULSE_ENABLE(pulse));

  bfpc_far_model u_bfpc_far_model (
    .ref_clk(clk), .rst_n(rst_n), .fail_cmd(fail_cmd), .io_val(io_val), .out_cmd(so),
    .func_sel(end_sel), .bus_fail(bus_fail), .io_image(io_img), .io_out(io_out),
    .drive_func(drive_func));

  // --------------------------------------------------------------------------
  // Checking and reporting
  // --------------------------------------------------------------------------
  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe, so compare mid-cycle.
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen && notes.size() > 0) begin
      n = notes.pop_front();
      chk("read data", n.e, reg_rdata & n.m);
    end
  end

  // A hung design must still reach the verdict.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end

  // --------------------------------------------------------------------------
  // Register port and sequencing helpers
  // --------------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    notes.push_back({e & m, m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Counts cycles until pulses drop; the drop must come inside [lo, hi].
  task automatic cut_within(input int lo, input int hi);
    int c;
    c = 0;
    while (pulse === 1'b1 && c < hi) begin
      tick(1);
      c++;
    end
    chk("pulse hold long enough", 32'h1, 32'(c >= lo));
    chk("pulse enable", 32'h0, 32'(pulse));
  endtask : cut_within

  task automatic break_bus(input logic f);
    @(posedge clk);
    fail_cmd <= f;
    tick(1);
  endtask : break_bus

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    tick(16);
    rst_n <= 1'b1;
    tick(3);
    // Reset values, unmapped place and read-back.
    rd(REG_DELAY, 32'h0, '1);
    rd(REG_STATE, 32'h4, '1);
    wr(4'h5, 32'hFFFF_FFFF);
    rd(4'h5, 32'h0, '1);
    wr(REG_MASK, 32'h7);
    // Zero delay cuts at once.
    break_bus(1'b1);
    cut_within(0, 3);
    tick(1);
    chk("safety outputs", 32'h0, 32'(so));
    chk("interrupt", 32'h1, 32'(irq));
    break_bus(1'b0);
    tick(3);
    rd(REG_STATUS, 32'h1, 32'h1);
    rd(REG_STATUS, 32'h0, 32'h7);
    // Delayed cut with frozen images and held outputs.
    wr(REG_DELAY, 32'h3);
    rd(REG_DELAY, 32'h3, '1);
    v = 8'($random(seed));
    w = 8'($random(seed));
    so_in <= v;
    io_val <= w;
    end_sel <= 2'h1;
    tick(4);
    break_bus(1'b1);
    tick(1);
    so_in <= ~v;
    io_val <= ~w;
    end_sel <= 2'h2;
    sec_sel <= 1'b1;
    li <= 8'($random(seed));
    tick(2);
    chk("held outputs", 32'(v), 32'(so));
    chk("bus input image", 32'(w), 32'(lx));
    chk("local image", 32'(li), 32'(li_img));
    chk("end position stage", 32'h1, 32'(end_act));
    chk("monitor enable", 32'h0, 32'(mon_en));
    chk("secondary enable", 32'h0, 32'(sec_en));
    chk("module outputs", 32'h0, 32'(io_out));
    chk("drive function", 32'h1, 32'(drive_func));
    cut_within(7, 14);
    tick(1);
    chk("safety outputs", 32'h0, 32'(so));
    rd(REG_STATUS, 32'h5, 32'h7);
    wr(REG_MASK, 32'h0);
    tick(1);
    chk("interrupt masked", 32'h0, 32'(irq));
    break_bus(1'b0);
    sec_sel <= 1'b0;
    tick(3);
    chk("monitor enable", 32'h1, 32'(mon_en));
    chk("pulse enable", 32'h1, 32'(pulse));
    // A secondary stop is honoured while the bus is healthy.
    sec_stop <= 1'b1;
    tick(2);
    chk("secondary stop", 32'h0, 32'(pulse));
    sec_stop <= 1'b0;
    tick(2);
    chk("pulse enable", 32'h1, 32'(pulse));
    // Each immediate cause overrides a long delay.
    wr(REG_DELAY, 32'd20);
    for (int k = 0; k < 6; k++) begin
      wr(REG_STOPCFG, k == 4 ? 32'h1 : (k == 5 ? 32'h100 : 32'h0));
      rd(REG_STATUS, 32'h0, 32'h7);
      stage <= (k == 4) ? 4'h2 : 4'h0;
      break_bus(1'b1);
      sec_stop <= 1'b1;
      tick(4);
      chk("pulse kept", 32'h1, 32'(pulse));
      if (k < 4) cs <= 4'(1 << k);
      else stage <= (k == 4) ? 4'h3 : 4'h4;
      cut_within(0, 4);
      rd(REG_STATUS, 32'h3, 32'h7);
      cs <= 4'h0;
      stage <= 4'h0;
      sec_stop <= 1'b0;
      break_bus(1'b0);
      tick(4);
    end
    // Standstill already selected at the failure instant cuts at once.
    cs <= 4'h4;
    break_bus(1'b1);
    cut_within(0, 3);
    rd(REG_STATUS, 32'h3, 32'h7);
    tick(2);
    stop_test();
  end
endmodule : tb
`default_nettype wire
